// [verilog/usc_pkg.sv]
package usc_pkg;

    // ------------------------------------------------------------------
    // Register map and field layout
    // ------------------------------------------------------------------
    localparam logic [7:0] USC_OFF_DEV_ADDR_A  = 8'h10;
    localparam logic [7:0] USC_OFF_EP0_MODE_A  = 8'h12;
    localparam logic [7:0] USC_OFF_STAT_CTRL   = 8'h1F;
    localparam logic [7:0] USC_OFF_DEV_ADDR_B  = 8'h40;
    localparam logic [7:0] USC_OFF_EP0_MODE_B  = 8'h42;
    localparam logic [7:0] USC_REG_RST         = 8'h00;

    localparam int USC_SC_EP_SIZE  = 7;
    localparam int USC_SC_EP_MODE  = 6;
    localparam int USC_SC_DP_LEVEL = 5;
    localparam int USC_SC_DM_LEVEL = 4;
    localparam int USC_SC_BUS_ACT  = 3;
    localparam int USC_DA_ENABLE   = 7;
    localparam int USC_E0_SETUP    = 7;
    localparam int USC_E0_IN       = 6;
    localparam int USC_E0_OUT      = 5;
    localparam int USC_E0_ACK      = 4;

    // Drive override codes
    localparam logic [2:0] USC_OVR_SIE     = 3'h0;
    localparam logic [2:0] USC_OVR_J       = 3'h1;
    localparam logic [2:0] USC_OVR_K       = 3'h2;
    localparam logic [2:0] USC_OVR_SE0     = 3'h3;
    localparam logic [2:0] USC_OVR_LOW     = 3'h4;
    localparam logic [2:0] USC_OVR_DPZ     = 3'h5;
    localparam logic [2:0] USC_OVR_DMZ     = 3'h6;
    localparam logic [2:0] USC_OVR_FLOAT   = 3'h7;

    // ------------------------------------------------------------------
    // Endpoint buffer slots in shared RAM
    // ------------------------------------------------------------------
    localparam logic [7:0] USC_SLOT_A8 = 8'hA8;
    localparam logic [7:0] USC_SLOT_B0 = 8'hB0;
    localparam logic [7:0] USC_SLOT_B8 = 8'hB8;
    localparam logic [7:0] USC_SLOT_C0 = 8'hC0;
    localparam logic [7:0] USC_SLOT_D8 = 8'hD8;
    localparam logic [7:0] USC_SLOT_E0 = 8'hE0;
    localparam logic [7:0] USC_SLOT_E8 = 8'hE8;
    localparam logic [7:0] USC_SLOT_F0 = 8'hF0;
    localparam logic [7:0] USC_SLOT_F8 = 8'hF8;
    localparam logic [5:0] USC_BUF_SMALL = 6'h08;
    localparam logic [5:0] USC_BUF_LARGE = 6'h20;
    localparam int         USC_NPIPE     = 7;

    // CPU stall per byte that the engine writes into a buffer
    localparam logic [3:0] USC_STALL_PER_BYTE = 4'h3;
    localparam logic [3:0] USC_STALL_MAX      = 4'hF;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic       valid;
        logic [6:0] addr;
    } usc_token_t;

    typedef struct packed {
        logic valid;
        logic devB;
        logic setup;
        logic inTok;
        logic outTok;
        logic ack;
    } usc_flag_evt_t;

    typedef struct packed {
        logic [7:0] base;
        logic [5:0] size;
        logic       used;
        logic       bidir;
    } usc_pipe_t;

    typedef usc_pipe_t [USC_NPIPE-1:0] usc_pipe_map_t;

    typedef struct packed {
        logic dpOut;
        logic dpOe;
        logic dmOut;
        logic dmOe;
    } usc_drive_t;

    typedef struct packed {
        logic [7:0]    statCtrl;
        logic [7:0]    devAddrA;
        logic [7:0]    devAddrB;
        logic [7:0]    ep0ModeA;
        logic [7:0]    ep0ModeB;
        logic          lockA;
        logic          lockB;
        logic [1:0]    dpSync;
        logic [1:0]    dmSync;
        logic [7:0]    rdData;
        logic [3:0]    stallCnt;
        logic          eopReq;
        logic          acceptA;
        logic          acceptB;
        usc_drive_t    drive;
        usc_pipe_map_t pipes;
    } usc_state_t;

endpackage

// [verilog/usc_upstream_ctrl.sv]
`timescale 1ns/1ns
module usc_upstream_ctrl
    import usc_pkg::*;
(
    // Clock and reset
    input  wire logic          core_clk,
    input  wire logic          rst,
    // Register port
    input  wire logic [7:0]    regAddr,
    input  wire logic [7:0]    regWrData,
    input  wire logic          regWr,
    input  wire logic          regRd,
    output      logic [7:0]    regRdData,
    // Upstream pins
    input  wire logic          dpIn,
    input  wire logic          dmIn,
    output      logic          dpOut,
    output      logic          dpOe,
    output      logic          dmOut,
    output      logic          dmOe,
    // Serial engine side
    input  wire usc_drive_t    sieDrive,
    input  wire logic          sieBusEvt,
    input  wire usc_token_t    sieToken,
    input  wire usc_flag_evt_t sieFlagEvt,
    input  wire logic          sieFifoWr,
    input  wire logic          sieEof1,
    output      logic          tokAcceptA,
    output      logic          tokAcceptB,
    output      logic          hubEopReq,
    // CPU and buffer map
    output      logic          cpuStall,
    output      usc_pipe_map_t pipeMap
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    localparam usc_state_t USC_STATE_RST = '0;

    usc_state_t st_r;
    usc_state_t st_nxt;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // One pipe entry
    function automatic usc_pipe_t mkPipe(input logic [7:0] base,
                                         input logic [5:0] size,
                                         input logic       bidir);
        usc_pipe_t p;
        p.base  = base;
        p.size  = size;
        p.used  = 1'b1;
        p.bidir = bidir;
        return p;
    endfunction

    // Buffer map per size/mode selection; index 0..4 first address, 5..6
    // second address. Only pipe zero of each address is bidirectional.
    function automatic usc_pipe_map_t mkMap(input logic szSel,
                                            input logic modeSel);
        usc_pipe_map_t m;
        m = '0;
        case ({szSel, modeSel})
            2'b00: begin
                m[0] = mkPipe(USC_SLOT_F8, USC_BUF_SMALL, 1'b1);
                m[1] = mkPipe(USC_SLOT_F0, USC_BUF_SMALL, 1'b0);
                m[2] = mkPipe(USC_SLOT_E8, USC_BUF_SMALL, 1'b0);
                m[5] = mkPipe(USC_SLOT_E0, USC_BUF_SMALL, 1'b1);
                m[6] = mkPipe(USC_SLOT_D8, USC_BUF_SMALL, 1'b0);
            end
            2'b10: begin
                m[5] = mkPipe(USC_SLOT_A8, USC_BUF_SMALL, 1'b1);
                m[6] = mkPipe(USC_SLOT_B0, USC_BUF_SMALL, 1'b0);
                m[0] = mkPipe(USC_SLOT_B8, USC_BUF_SMALL, 1'b1);
                m[1] = mkPipe(USC_SLOT_C0, USC_BUF_LARGE, 1'b0);
                m[2] = mkPipe(USC_SLOT_E0, USC_BUF_LARGE, 1'b0);
            end
            2'b01: begin
                m[0] = mkPipe(USC_SLOT_F8, USC_BUF_SMALL, 1'b1);
                m[1] = mkPipe(USC_SLOT_F0, USC_BUF_SMALL, 1'b0);
                m[2] = mkPipe(USC_SLOT_E8, USC_BUF_SMALL, 1'b0);
                m[3] = mkPipe(USC_SLOT_E0, USC_BUF_SMALL, 1'b0);
                m[4] = mkPipe(USC_SLOT_D8, USC_BUF_SMALL, 1'b0);
            end
            2'b11: begin
                m[3] = mkPipe(USC_SLOT_A8, USC_BUF_SMALL, 1'b0);
                m[4] = mkPipe(USC_SLOT_B0, USC_BUF_SMALL, 1'b0);
                m[0] = mkPipe(USC_SLOT_B8, USC_BUF_SMALL, 1'b1);
                m[1] = mkPipe(USC_SLOT_C0, USC_BUF_LARGE, 1'b0);
                m[2] = mkPipe(USC_SLOT_E0, USC_BUF_LARGE, 1'b0);
            end
            default: m = '0;
        endcase
        return m;
    endfunction

    // Zero-mode register update. The engine's set beats a CPU clear in
    // the same cycle; a locked register ignores CPU writes to bits 6..0.
    function automatic logic [7:0] ep0Next(input logic [7:0] cur,
                                           input logic       locked,
                                           input logic       wr,
                                           input logic [7:0] wd,
                                           input logic       evt,
                                           input usc_flag_evt_t f);
        logic [7:0] n;
        n = cur;
        if (wr) begin
            n[USC_E0_SETUP] = 1'b0;
            if (!locked) begin
                n[6:0] = wd[6:0];
            end
        end
        if (evt) begin
            if (f.setup) n[USC_E0_SETUP] = 1'b1;
            if (f.inTok) n[USC_E0_IN]    = 1'b1;
            if (f.outTok) n[USC_E0_OUT]  = 1'b1;
            if (f.ack) n[USC_E0_ACK]     = 1'b1;
        end
        return n;
    endfunction

    // ------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------
    logic       wrStat;
    logic       wrDevA;
    logic       wrDevB;
    logic       wrE0A;
    logic       wrE0B;
    logic       rdE0A;
    logic       rdE0B;
    logic       oneAddr;
    logic       evtA;
    logic       evtB;
    logic [2:0] ovrCode;
    logic [7:0] statView;

    // Register strobes and engine flag routing
    always_comb begin
        wrStat  = regWr && (regAddr == USC_OFF_STAT_CTRL);
        wrDevA  = regWr && (regAddr == USC_OFF_DEV_ADDR_A);
        wrDevB  = regWr && (regAddr == USC_OFF_DEV_ADDR_B);
        wrE0A   = regWr && (regAddr == USC_OFF_EP0_MODE_A);
        wrE0B   = regWr && (regAddr == USC_OFF_EP0_MODE_B);
        rdE0A   = regRd && (regAddr == USC_OFF_EP0_MODE_A);
        rdE0B   = regRd && (regAddr == USC_OFF_EP0_MODE_B);
        oneAddr = st_r.statCtrl[USC_SC_EP_MODE];
        // In single-address mode 0x42 is not a control pipe register
        evtA    = sieFlagEvt.valid && !sieFlagEvt.devB;
        evtB    = sieFlagEvt.valid && sieFlagEvt.devB && !oneAddr;
        ovrCode = st_r.statCtrl[2:0];
        // Live levels replace the stored bits on read
        statView = st_r.statCtrl;
        statView[USC_SC_DP_LEVEL] = st_r.dpSync[1];
        statView[USC_SC_DM_LEVEL] = st_r.dmSync[1];
    end

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;

        // Pin synchronisers
        st_nxt.dpSync = {st_r.dpSync[0], dpIn};
        st_nxt.dmSync = {st_r.dmSync[0], dmIn};

        // Status and control; level bits are never stored
        if (wrStat) begin
            st_nxt.statCtrl[7:6] = regWrData[7:6];
            st_nxt.statCtrl[2:0] = regWrData[2:0];
            if (!regWrData[USC_SC_BUS_ACT]) begin
                st_nxt.statCtrl[USC_SC_BUS_ACT] = 1'b0;
            end
        end
        st_nxt.statCtrl[5:4] = 2'b00;
        // Engine set wins over a clearing write
        if (sieBusEvt) begin
            st_nxt.statCtrl[USC_SC_BUS_ACT] = 1'b1;
        end

        // Device addresses
        if (wrDevA) st_nxt.devAddrA = regWrData;
        if (wrDevB) st_nxt.devAddrB = regWrData;

        // Zero-mode registers and their write locks
        st_nxt.ep0ModeA = ep0Next(st_r.ep0ModeA, st_r.lockA, wrE0A,
                                  regWrData, evtA, sieFlagEvt);
        st_nxt.ep0ModeB = ep0Next(st_r.ep0ModeB, st_r.lockB && !oneAddr,
                                  wrE0B, regWrData, evtB, sieFlagEvt);
        if (rdE0A) st_nxt.lockA = 1'b0;
        if (evtA) st_nxt.lockA = 1'b1;
        if (rdE0B) st_nxt.lockB = 1'b0;
        if (evtB) st_nxt.lockB = 1'b1;

        // Token address match against enabled addresses
        st_nxt.acceptA = sieToken.valid && st_r.devAddrA[USC_DA_ENABLE]
                         && (sieToken.addr == st_r.devAddrA[6:0]);
        st_nxt.acceptB = sieToken.valid && st_r.devAddrB[USC_DA_ENABLE]
                         && !oneAddr
                         && (sieToken.addr == st_r.devAddrB[6:0]);

        // Read data, one cycle after the strobe; zero otherwise
        st_nxt.rdData = '0;
        if (regRd) begin
            case (regAddr)
                USC_OFF_STAT_CTRL:  st_nxt.rdData = statView;
                USC_OFF_DEV_ADDR_A: st_nxt.rdData = st_r.devAddrA;
                USC_OFF_DEV_ADDR_B: st_nxt.rdData = st_r.devAddrB;
                USC_OFF_EP0_MODE_A: st_nxt.rdData = st_r.ep0ModeA;
                USC_OFF_EP0_MODE_B: st_nxt.rdData = st_r.ep0ModeB;
                default:            st_nxt.rdData = '0;
            endcase
        end

        // Stall budget; saturates so a burst cannot wrap it
        if (st_r.stallCnt != '0) begin
            st_nxt.stallCnt = st_r.stallCnt - 4'h1;
        end
        if (sieFifoWr) begin
            if (st_nxt.stallCnt > USC_STALL_MAX - USC_STALL_PER_BYTE) begin
                st_nxt.stallCnt = USC_STALL_MAX;
            end else begin
                st_nxt.stallCnt = st_nxt.stallCnt + USC_STALL_PER_BYTE;
            end
        end

        // End-of-packet request at the frame's EOF1 point
        st_nxt.eopReq = sieEof1;

        // Upstream drive, registered from the next override value so a
        // write takes the pins at the following edge
        case (st_nxt.statCtrl[2:0])
            USC_OVR_SIE:   st_nxt.drive = sieDrive;
            USC_OVR_J:     st_nxt.drive = 4'b1101;
            USC_OVR_K:     st_nxt.drive = 4'b0111;
            USC_OVR_SE0:   st_nxt.drive = 4'b0101;
            USC_OVR_LOW:   st_nxt.drive = 4'b0101;
            USC_OVR_DPZ:   st_nxt.drive = 4'b0001;
            USC_OVR_DMZ:   st_nxt.drive = 4'b0100;
            USC_OVR_FLOAT: st_nxt.drive = 4'b0000;
            default:       st_nxt.drive = 4'b0000;
        endcase

        // Buffer map follows the size and mode bits
        st_nxt.pipes = mkMap(st_nxt.statCtrl[USC_SC_EP_SIZE],
                             st_nxt.statCtrl[USC_SC_EP_MODE]);
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    // Reset clears addresses, modes and status
    always_ff @(posedge core_clk) begin
        if (rst) begin
            st_r <= USC_STATE_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Outputs
    assign regRdData  = st_r.rdData;
    assign dpOut      = st_r.drive.dpOut;
    assign dpOe       = st_r.drive.dpOe;
    assign dmOut      = st_r.drive.dmOut;
    assign dmOe       = st_r.drive.dmOe;
    assign tokAcceptA = st_r.acceptA;
    assign tokAcceptB = st_r.acceptB;
    assign hubEopReq  = st_r.eopReq;
    assign cpuStall   = (st_r.stallCnt != '0);
    assign pipeMap    = st_r.pipes;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    a_sie_passthru: assert property (
        (!regWr && ovrCode == USC_OVR_SIE) |=> (st_r.drive == $past(sieDrive))
    ) else $error("engine drive not passed through");

    a_force_j: assert property (
        (wrStat && regWrData[2:0] == USC_OVR_J) |=>
            (dpOut && dpOe && !dmOut && dmOe)
    ) else $error("J override not driven");

    a_force_low: assert property (
        (ovrCode == USC_OVR_SE0 || ovrCode == USC_OVR_LOW) |->
            (!dpOut && dpOe && !dmOut && dmOe)
    ) else $error("both lines not driven low");

    a_float_lines: assert property (
        (ovrCode == USC_OVR_FLOAT) |-> (!dpOe && !dmOe)
    ) else $error("lines not floated");

    a_busact_set: assert property (
        sieBusEvt |=> st_r.statCtrl[USC_SC_BUS_ACT] [*2] or
            (st_r.statCtrl[USC_SC_BUS_ACT] ##1 $past(wrStat))
    ) else $error("bus activity not set");

    a_busact_clear: assert property (
        (wrStat && !regWrData[USC_SC_BUS_ACT] && !sieBusEvt) |=>
            !st_r.statCtrl[USC_SC_BUS_ACT]
    ) else $error("bus activity not cleared");

    a_busact_keep: assert property (
        (wrStat && regWrData[USC_SC_BUS_ACT]) |=>
            (st_r.statCtrl[USC_SC_BUS_ACT] ==
             ($past(st_r.statCtrl[USC_SC_BUS_ACT]) || $past(sieBusEvt)))
    ) else $error("bus activity changed by writing one");

    a_level_read: assert property (
        (regRd && regAddr == USC_OFF_STAT_CTRL) |=>
            (regRdData[USC_SC_DP_LEVEL] == $past(st_r.dpSync[1]) &&
             regRdData[USC_SC_DM_LEVEL] == $past(st_r.dmSync[1]))
    ) else $error("line level read wrong");

    a_addr_disabled: assert property (
        (sieToken.valid && !st_r.devAddrA[USC_DA_ENABLE]) |=> !tokAcceptA
    ) else $error("token accepted on disabled address");

    a_addr_match: assert property (
        tokAcceptA |-> ($past(sieToken.addr) == $past(st_r.devAddrA[6:0]))
    ) else $error("token accepted with wrong address");

    a_stall_three: assert property (
        (sieFifoWr && !cpuStall) |=> cpuStall [*3]
    ) else $error("stall shorter than three cycles");

    a_setup_clear: assert property (
        (wrE0A && !evtA) |=> !st_r.ep0ModeA[USC_E0_SETUP]
    ) else $error("setup flag not cleared by write");

    a_in_seen: assert property (
        (evtA && sieFlagEvt.inTok) |=> st_r.ep0ModeA[USC_E0_IN]
    ) else $error("in-seen flag not set");

    a_eop_gen: assert property (
        sieEof1 |=> hubEopReq
    ) else $error("no end-of-packet at EOF1");

    c_busact_clear: cover property (
        st_r.statCtrl[USC_SC_BUS_ACT] ##1 wrStat ##1
            !st_r.statCtrl[USC_SC_BUS_ACT]
    );
    c_setup_seen: cover property (evtA && sieFlagEvt.setup ##1 rdE0A);
    c_stall_run: cover property (sieFifoWr ##3 sieFifoWr);
    c_override: cover property (wrStat && regWrData[2:0] == USC_OVR_K);

endmodule

// [dv/usc_host_model.sv]
`timescale 1ns/1ns
// ------------------------------------------------------------
// Upstream host side of the two data lines
// ------------------------------------------------------------
module usc_host_model (
    // Device drive
    input  wire logic dpOut,
    input  wire logic dpOe,
    input  wire logic dmOut,
    input  wire logic dmOe,
    // Host drive
    input  wire logic hostOe,
    input  wire logic hostDp,
    input  wire logic hostDm,
    // Resolved lines
    output      logic dpIn,
    output      logic dmIn
);
    // Released lines fall to the pull levels, never hold the last value
    assign dpIn = dpOe ? dpOut : (hostOe ? hostDp : 1'b1);
    assign dmIn = dmOe ? dmOut : (hostOe ? hostDm : 1'b0);
endmodule

// [dv/usc_upstream_ctrl_and_endpoint_config_bench.sv]
`timescale 1ns/1ns
// ------------------------------------------------------------
// Bench for upstream control and pipe map
// ------------------------------------------------------------
module usc_upstream_ctrl_and_endpoint_config_bench;
    import usc_pkg::*;
    logic          core_clk = 0, rst = 1, regWr = 0, regRd = 0;
    logic [7:0]    regAddr = 0, regWrData = 0, regRdData, d, e;
    logic          dpIn, dmIn, dpOut, dpOe, dmOut, dmOe, hubEopReq;
    logic          sieBusEvt = 0, sieFifoWr = 0, sieEof1 = 0, cpuStall;
    logic          tokAcceptA, tokAcceptB, hostOe = 1;
    logic          hostDp = 1, hostDm = 0;
    logic [6:0]    aA, aB;
    usc_drive_t    sieDrive = '0;
    usc_token_t    sieToken = '0;
    usc_flag_evt_t sieFlagEvt = '0;
    usc_pipe_map_t pipeMap;
    int            miscompares = 0, checksDone = 0, i, n, k;
    logic [55:0]   baseTab [4];
    usc_upstream_ctrl u_usc_upstream_ctrl (.core_clk, .rst, .regAddr,
        .regWrData, .regWr, .regRd, .regRdData, .dpIn, .dmIn, .dpOut,
        .dpOe, .dmOut, .dmOe, .sieDrive, .sieBusEvt, .sieToken,
        .sieFlagEvt, .sieFifoWr, .sieEof1, .tokAcceptA, .tokAcceptB,
        .hubEopReq, .cpuStall, .pipeMap);
    usc_host_model u_usc_host_model (.dpOut, .dpOe, .dmOut, .dmOe,
        .hostOe, .hostDp, .hostDm, .dpIn, .dmIn);
    initial begin
        forever #5 core_clk = ~core_clk;
    end
    // Helpers: compare, bus cycles, expectations
    task automatic chk(input string nm, input logic [7:0] e, g);
        checksDone++;
        if (g !== e) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, v);
        @(posedge core_clk);
        regAddr   <= a;
        regWrData <= v;
        regWr     <= 1'b1;
        @(posedge core_clk);
        regWr     <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge core_clk);
        regAddr <= a;
        regRd   <= 1'b1;
        @(posedge core_clk);
        regRd   <= 1'b0;
        #1 v = regRdData;
    endtask
    task automatic tok(input logic [6:0] t, input logic eA, eB);
        @(posedge core_clk);
        sieToken <= '{1'b1, t};
        @(posedge core_clk);
        sieToken.valid <= 1'b0;
        #1 chk("accept", {6'h0, eA, eB}, {6'h0, tokAcceptA, tokAcceptB});
    endtask
    // Float lines carry no level, so only driven values are compared
    function automatic logic [3:0] msk(input usc_drive_t s);
        msk = {s.dpOut & s.dpOe, s.dpOe, s.dmOut & s.dmOe, s.dmOe};
    endfunction
    function automatic logic [3:0] expDrv(input int c, input usc_drive_t s);
        case (c)
            0: expDrv = msk(s);
            1: expDrv = 4'b1101;
            2: expDrv = 4'b0111;
            3, 4: expDrv = 4'b0101;
            5: expDrv = 4'b0001;
            6: expDrv = 4'b0100;
            default: expDrv = 4'b0000;
        endcase
    endfunction
    task automatic close_out;
        $display("checks %0d miscompares %0d", checksDone, miscompares);
        if (miscompares == 0 && checksDone > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // Main sequence
    initial begin
        void'($urandom(32'h11dc));
        baseTab = '{56'hF8_F0E8_0000_E0D8, 56'hF8_F0E8_E0D8_0000,
                    56'hB8_C0E0_0000_A8B0, 56'hB8_C0E0_A8B0_0000};
        repeat (4) @(posedge core_clk);
        rst <= 1'b0;
        foreach (baseTab[i]) begin
            rd(8'h10 + 8'h30 * (i / 2) + 8'h02 * (i % 2), d);
            chk("resetVal", 8'h00, d);
        end
        wr(8'h11, 8'h5A);
        rd(8'h11, d);
        chk("unmapped", 8'h00, d);
        for (i = 0; i < 16; i++) begin
            @(posedge core_clk);
            sieDrive <= usc_drive_t'($urandom);
            wr(USC_OFF_STAT_CTRL, 8'(i % 8));
            #1 d = 8'(msk({dpOut, dpOe, dmOut, dmOe}));
            chk("drive", 8'(expDrv(i%8, sieDrive)), d);
        end
        for (i = 0; i < 6; i++) begin
            hostDp <= 1'($urandom);
            hostDm <= 1'($urandom);
            wr(USC_OFF_STAT_CTRL, 8'h37);
            repeat (3) @(posedge core_clk);
            rd(USC_OFF_STAT_CTRL, d);
            chk("lines", {2'b0, hostDp, hostDm, 4'h7}, d & 8'h3F);
        end
        wr(USC_OFF_STAT_CTRL, 8'h00);
        rd(USC_OFF_STAT_CTRL, d);
        chk("busActIdle", 8'h0, {7'h0, d[3]});
        @(posedge core_clk);
        sieBusEvt <= 1'b1;
        @(posedge core_clk);
        sieBusEvt <= 1'b0;
        wr(USC_OFF_STAT_CTRL, 8'h08);
        rd(USC_OFF_STAT_CTRL, d);
        chk("busActSet", 8'h1, {7'h0, d[3]});
        wr(USC_OFF_STAT_CTRL, 8'h00);
        rd(USC_OFF_STAT_CTRL, d);
        chk("busActClr", 8'h0, {7'h0, d[3]});
        for (n = 0; n < 4; n++) begin
            wr(USC_OFF_STAT_CTRL, 8'(n << 6));
            repeat (2) @(posedge core_clk);
            for (i = 0; i < USC_NPIPE; i++) begin
                d = baseTab[n][8 * (6 - i) +: 8];
                if (d !== 8'h00) begin
                    chk("pipeBase", d, pipeMap[i].base);
                    e = (n > 1 && d >= 8'hC0) ? 8'h20 : 8'h08;
                    chk("pipeSize", e, 8'(pipeMap[i].size));
                    chk("pipeDir", 8'(i%5 == 0), 8'(pipeMap[i].bidir));
                end
            end
        end
        wr(USC_OFF_STAT_CTRL, 8'h00);
        aA = 7'($urandom_range(1, 63));
        aB = aA + 7'h40;
        wr(USC_OFF_DEV_ADDR_A, {1'b1, aA});
        wr(USC_OFF_DEV_ADDR_B, {1'b1, aB});
        tok(aA, 1'b1, 1'b0);
        tok(aB, 1'b0, 1'b1);
        tok(aA ^ 7'h01, 1'b0, 1'b0);
        wr(USC_OFF_DEV_ADDR_A, {1'b0, aA});
        tok(aA, 1'b0, 1'b0);
        wr(USC_OFF_STAT_CTRL, 8'h40);
        tok(aB, 1'b0, 1'b0);
        for (n = 1; n < 3; n++) begin
            @(posedge core_clk);
            sieFifoWr <= 1'b1;
            i = 0;
            // Count from the first stalled cycle so a burst is seen whole
            for (k = 0; k < 20; k++) begin
                @(posedge core_clk);
                if (k == n - 1) sieFifoWr <= 1'b0;
                #1 i += int'(cpuStall);
            end
            chk("stallCycles", 8'(3 * n), 8'(i));
        end
        @(posedge core_clk);
        sieEof1 <= 1'b1;
        @(posedge core_clk);
        sieEof1 <= 1'b0;
        #1 chk("eop", 8'h1, {7'h0, hubEopReq});
        wr(USC_OFF_STAT_CTRL, 8'h00);
        @(posedge core_clk);
        sieFlagEvt <= '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1};
        @(posedge core_clk);
        sieFlagEvt <= '0;
        rd(USC_OFF_EP0_MODE_A, d);
        chk("setupSeen", 8'h90, d);
        wr(USC_OFF_EP0_MODE_A, 8'h85);
        rd(USC_OFF_EP0_MODE_A, d);
        chk("setupClr", 8'h05, d);
        @(posedge core_clk);
        sieFlagEvt <= '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
        @(posedge core_clk);
        sieFlagEvt <= '0;
        wr(USC_OFF_EP0_MODE_B, 8'h03);
        rd(USC_OFF_EP0_MODE_B, d);
        chk("inSeenLock", 8'h40, d);
        close_out();
    end
endmodule
